// ---- src/pfb_defs.svh ----
// Constants for the parallel flash bus controller
`ifndef PFB_DEFS_SVH
`define PFB_DEFS_SVH
`define PFB_REG_CTRL     4'h0
`define PFB_REG_ADDR     4'h1
`define PFB_REG_WDATA    4'h2
`define PFB_REG_RDATA    4'h3
`define PFB_REG_STATUS   4'h4
`define PFB_REG_ID       4'h5
`define PFB_CMD_WRITE    0
`define PFB_CMD_READ     1
`define PFB_CMD_HVID     2
`define PFB_CTL_WORD     3
`define PFB_CTL_CLEAR    4
`define PFB_CTL_UNPROT   5
`define PFB_SETUP_CYC    3'h2
`define PFB_STROBE_CYC   3'h4
`define PFB_HOLD_CYC     3'h2
`define PFB_RESET_CMD    16'h00f0
`define PFB_ADDR_A8      8
`define PFB_ADDR_A6      6
`define PFB_ADDR_A1      1
`define PFB_ADDR_A0      0
`define PFB_ID_DEFAULT   16'h00a5
`endif

// ---- src/pfb_pkg.sv ----
// Types for the parallel flash bus controller
package pfb_pkg;
    typedef enum logic [3:0] {
        PFB_IDLE   = 4'b0001,
        PFB_SETUP  = 4'b0010,
        PFB_STROBE = 4'b0100,
        PFB_HOLD   = 4'b1000
    } pfb_state_t;
endpackage : pfb_pkg

// ---- src/pfb_host.sv ----
// Host controller driving a parallel NOR flash through its bus pins
// Function
// - Host issues reset command after timeout bit high or leaving identification; this controller never sends PFB_RESET_CMD itself, software must write it.
// - High-voltage ident: host sets elevated sense and address bits 8,6,1,0; this controller raises only elevated sense, software sets the bits.
// - Ident also reachable by command sequence without elevated voltage.
// - Host writes with chip select and write strobe low, output drive high.
// - Host drives low byte in byte mode, all sixteen lines in word mode.
// - Completion shows on ready/busy pin and polling and toggle bits.
// - Protect all other sectors before unprotecting one, via elevated clear pin; this controller only raises the pin, software must protect first.
//
// Implementation choices: the placing of the registers and strobed register access.
`include "pfb_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module pfb_host (
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    // Register port
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // Flash control pins
    output logic             flash_ce_n_out,
    output logic             flash_oe_n_out,
    output logic             flash_we_n_out,
    output logic             flash_clear_n_out,
    output logic             flash_word_out,
    output logic             flash_clear_hv_out,
    output logic             high_voltage_sense_addr_out,
    output logic [18:0]      flash_addr_out,
    // Flash data pins
    input  wire logic [15:0] flash_dq_in,
    output logic      [15:0] flash_dq_out,
    output logic      [15:0] flash_dq_oe_n_out,
    // Flash status
    input  wire logic        ready_busy_in
);
    pfb_pkg::pfb_state_t state_q, state_d;
    logic [2:0]  cnt_q;
    logic [7:0]  ctrl_q;
    logic [19:0] addr_q;
    logic [15:0] wdata_q, rdata_q;
    logic        is_read_q, hv_q, busy_q, rdy_q;
    logic [31:0] rdata_q2;
    logic [15:0] id_q;

    wire         wr_ctrl   = reg_wr_in && (reg_addr_in == `PFB_REG_CTRL);
    wire         start_wr  = wr_ctrl && reg_wdata_in[`PFB_CMD_WRITE] && !busy_q;
    wire         start_rd  = wr_ctrl && reg_wdata_in[`PFB_CMD_READ] && !reg_wdata_in[`PFB_CMD_WRITE] && !busy_q;
    wire         word_mode = ctrl_q[`PFB_CTL_WORD];
    wire         cnt_done  = (cnt_q == 3'h0);
    wire         in_cycle  = (state_q != pfb_pkg::PFB_IDLE);
    wire         strobing  = (state_q == pfb_pkg::PFB_STROBE);
    // Byte mode puts the byte address bit on the top data line
    wire [15:0]  dq_drive  = word_mode ? wdata_q : {addr_q[0], 7'h00, wdata_q[7:0]};
    wire [15:0]  dq_oe_wr  = word_mode ? 16'h0000 : 16'h7f00;
    wire [15:0]  dq_oe_rd  = word_mode ? 16'hffff : 16'h7fff;
    wire [15:0]  rd_mask   = word_mode ? 16'hffff : 16'h00ff;

    always_comb begin
        state_d = state_q;
        case (state_q)
            pfb_pkg::PFB_IDLE:   if (start_wr || start_rd) state_d = pfb_pkg::PFB_SETUP;
            pfb_pkg::PFB_SETUP:  if (cnt_done) state_d = pfb_pkg::PFB_STROBE;
            pfb_pkg::PFB_STROBE: if (cnt_done) state_d = pfb_pkg::PFB_HOLD;
            pfb_pkg::PFB_HOLD:   if (cnt_done) state_d = pfb_pkg::PFB_IDLE;
            default:             state_d = pfb_pkg::PFB_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= pfb_pkg::PFB_IDLE;
            cnt_q   <= 3'h0;
        end else begin
            state_q <= state_d;
            if (state_q != state_d) begin
                cnt_q <= (state_d == pfb_pkg::PFB_SETUP)  ? `PFB_SETUP_CYC :
                         (state_d == pfb_pkg::PFB_STROBE) ? `PFB_STROBE_CYC : `PFB_HOLD_CYC;
            end else if (!cnt_done) begin
                cnt_q <= cnt_q - 3'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q    <= 8'h00;
            addr_q    <= 20'h00000;
            wdata_q   <= 16'h0000;
            is_read_q <= 1'b0;
            hv_q      <= 1'b0;
            id_q      <= `PFB_ID_DEFAULT;
        end else begin
            // Whole control word refused while busy so mode pins cannot shift mid-cycle
            if (wr_ctrl && !busy_q) ctrl_q <= reg_wdata_in[7:0];
            if (reg_wr_in && reg_addr_in == `PFB_REG_ADDR && !busy_q) addr_q <= reg_wdata_in[19:0];
            if (reg_wr_in && reg_addr_in == `PFB_REG_WDATA && !busy_q) wdata_q <= reg_wdata_in[15:0];
            if (reg_wr_in && reg_addr_in == `PFB_REG_ID) id_q <= reg_wdata_in[15:0];
            if (start_wr || start_rd) begin
                is_read_q <= start_rd;
                hv_q      <= start_rd && reg_wdata_in[`PFB_CMD_HVID];
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= 16'h0000;
            busy_q  <= 1'b0;
            rdy_q   <= 1'b0;
        end else begin
            busy_q <= (state_d != pfb_pkg::PFB_IDLE);
            rdy_q  <= ready_busy_in;
            // Sample at the end of the strobe so output access time has passed
            if (strobing && cnt_done && is_read_q) rdata_q <= flash_dq_in & rd_mask;
        end
    end

    // Busy refuses new cycles so a software slip cannot corrupt one in flight
    wire [31:0] status_w = {16'h0000, rdata_q[7], rdata_q[6], rdata_q[5], 10'h000, 1'b0, rdy_q, busy_q};

    wire [31:0] rd_mux =
        (reg_addr_in == `PFB_REG_CTRL)   ? {24'h000000, ctrl_q} :
        (reg_addr_in == `PFB_REG_ADDR)   ? {12'h000, addr_q} :
        (reg_addr_in == `PFB_REG_WDATA)  ? {16'h0000, wdata_q} :
        (reg_addr_in == `PFB_REG_RDATA)  ? {16'h0000, rdata_q} :
        (reg_addr_in == `PFB_REG_STATUS) ? status_w :
        (reg_addr_in == `PFB_REG_ID)     ? {16'h0000, id_q} : 32'h00000000;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) rdata_q2 <= 32'h00000000;
        else if (reg_rd_in) rdata_q2 <= rd_mux;
        else rdata_q2 <= 32'h00000000;
    end
    assign reg_rdata_out = rdata_q2;

    // Flash pins
    assign flash_ce_n_out     = !in_cycle;
    assign flash_oe_n_out     = !(in_cycle && is_read_q);
    assign flash_we_n_out     = !(strobing && !is_read_q);
    assign flash_clear_n_out  = !ctrl_q[`PFB_CTL_CLEAR];
    assign flash_clear_hv_out = ctrl_q[`PFB_CTL_UNPROT];
    assign flash_word_out     = word_mode;
    assign high_voltage_sense_addr_out = hv_q && in_cycle;
    assign flash_addr_out     = word_mode ? addr_q[18:0] : addr_q[19:1];
    assign flash_dq_out       = dq_drive;
    assign flash_dq_oe_n_out  = (in_cycle && !is_read_q) ? dq_oe_wr : dq_oe_rd;

    property p_we_cycle;
        @(posedge sys_clk_in) disable iff (rst_in)
        !flash_we_n_out |-> !flash_ce_n_out && flash_oe_n_out;
    endproperty
    a_we_cycle: assert property (p_we_cycle) else $error("write strobe without select or with output drive");

    property p_we_width;
        @(posedge sys_clk_in) disable iff (rst_in)
        $fell(flash_we_n_out) |-> !flash_we_n_out [*5] ##1 flash_we_n_out;
    endproperty
    a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

    property p_data_stable;
        @(posedge sys_clk_in) disable iff (rst_in)
        !flash_we_n_out |-> $stable(flash_dq_out) && $stable(flash_addr_out);
    endproperty
    a_data_stable: assert property (p_data_stable) else $error("bus moved during write strobe");

    property p_byte_lanes;
        @(posedge sys_clk_in) disable iff (rst_in)
        !flash_word_out |-> flash_dq_oe_n_out[14:8] == 7'h7f;
    endproperty
    a_byte_lanes: assert property (p_byte_lanes) else $error("middle lanes driven in byte mode");

    property p_rd_contention;
        @(posedge sys_clk_in) disable iff (rst_in)
        !flash_oe_n_out |-> flash_dq_oe_n_out[7:0] == 8'hff;
    endproperty
    a_rd_contention: assert property (p_rd_contention) else $error("host drives while flash outputs");

    property p_hv_read;
        @(posedge sys_clk_in) disable iff (rst_in)
        high_voltage_sense_addr_out |-> flash_we_n_out && !flash_ce_n_out;
    endproperty
    a_hv_read: assert property (p_hv_read) else $error("elevated sense during write");

    property p_cycle_len;
        @(posedge sys_clk_in) disable iff (rst_in)
        $fell(flash_ce_n_out) |-> !flash_ce_n_out [*8] ##1 !flash_ce_n_out [*3] ##1 flash_ce_n_out;
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("bus cycle length wrong");

    property p_rd_slot;
        @(posedge sys_clk_in) disable iff (rst_in)
        $past(reg_rd_in) == 1'b0 |-> reg_rdata_out == 32'h00000000;
    endproperty
    a_rd_slot: assert property (p_rd_slot) else $error("read data outside its cycle");

    // Mode pins must not move under a cycle in flight
    property p_mode_hold;
        @(posedge sys_clk_in) disable iff (rst_in)
        busy_q && $past(busy_q) |-> $stable(flash_word_out) && $stable(flash_clear_n_out);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode pins moved during a cycle");
endmodule : pfb_host
`default_nettype wire

// ---- tb/pfb_flash_model.sv ----
// Behavioural flash device on the controller's far side
`timescale 1ns/1ps
`default_nettype none
module pfb_flash_model #(
    parameter logic [15:0] MAKER_CODE = 16'h0042, // Arbitrary value
    parameter logic [15:0] CONT_CODE  = 16'h0033  // Arbitrary value
) (
    input  wire logic        ce_n_in, oe_n_in, we_n_in, clear_n_in, word_in, clear_hv_in, hv_in,
    input  wire logic [18:0] addr_in,
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out,
    output logic      [15:0] dq_oe_n_out,
    output logic             ready_busy_out
);
    logic [15:0] mem [0:15];
    logic [18:0] wa;
    logic        wlsb;
    wire         wr_n  = ce_n_in | we_n_in | ~oe_n_in | ~clear_n_in;
    wire         rd_en = ~ce_n_in & ~oe_n_in & clear_n_in;
    // Protection verify reports the protected top half as set
    wire  [15:0] rdat  = hv_in ? (addr_in[1] ? {15'h0000, addr_in[18]} : addr_in[8] ? MAKER_CODE : CONT_CODE)
                               : mem[addr_in[3:0]];
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 16'h1000 + 16'(i);
        ready_busy_out = 1'b1;
    end
    always @(negedge wr_n) begin
        wa   = addr_in;
        wlsb = dq_in[15];
    end
    // Top half of the array is the protected sector, so refused writes stay visible
    always @(posedge wr_n) begin
        if (!(wa[18] && !clear_hv_in) && dq_in[7:0] != 8'hf0) begin
            if (word_in) mem[wa[3:0]] = dq_in;
            else if (wlsb) mem[wa[3:0]][15:8] = dq_in[7:0];
            else mem[wa[3:0]][7:0] = dq_in[7:0];
        end
        ready_busy_out = 1'b0;
        #100 ready_busy_out = 1'b1;
    end
    assign dq_out      = word_in ? rdat : {8'h00, dq_in[15] ? rdat[15:8] : rdat[7:0]};
    assign dq_oe_n_out = !rd_en ? 16'hffff : word_in ? 16'h0000 : 16'hff00;
endmodule : pfb_flash_model
`default_nettype wire

// ---- tb/pfb_host_tb.sv ----
// Self-checking bench for the parallel flash bus controller
`timescale 1ns/1ps
`default_nettype none
module pfb_host_tb;
    localparam logic [15:0] MAKER = 16'h0042; // Arbitrary value
    localparam logic [15:0] CONT  = 16'h0033; // Arbitrary value
    typedef struct packed { logic [5:0] ctl; logic [19:0] addr; logic [15:0] wd, ex; } pfb_row_t;
    logic        sys_clk_in, rst_in, reg_wr_in, reg_rd_in, ce_n, oe_n, we_n, clr_n, word, clr_hv, hv, rb;
    logic [3:0]  reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, rd_v;
    logic [18:0] fa;
    logic [15:0] h_d, h_oe_n, f_d, f_oe_n;
    // Undriven lines show the inverse of the host's last value, never a kind guess
    wire  [15:0] dq = (~h_oe_n & h_d) | (h_oe_n & ~f_oe_n & f_d) | (h_oe_n & f_oe_n & ~h_d);
    int          n_fail, total_checks, cyc;
    pfb_row_t    rows [9] = '{
        '{6'h08, 20'h00005, 16'h0000, 16'h1005}, '{6'h08, 20'h00002, 16'h1234, 16'h1234},
        '{6'h00, 20'h00007, 16'h00ab, 16'h00ab}, '{6'h00, 20'h00006, 16'h0000, 16'h0003},
        '{6'h08, 20'h40001, 16'h5555, 16'h1001}, '{6'h0c, 20'h40002, 16'h0000, 16'h0001},
        '{6'h0c, 20'h00002, 16'h0000, 16'h0000},
        '{6'h0c, 20'h00000, 16'h0000, CONT},     '{6'h0c, 20'h00100, 16'h0000, MAKER}};
    pfb_host uut (.sys_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n), .flash_we_n_out(we_n), .flash_clear_n_out(clr_n),
        .flash_word_out(word), .flash_clear_hv_out(clr_hv), .high_voltage_sense_addr_out(hv),
        .flash_addr_out(fa), .flash_dq_in(dq), .flash_dq_out(h_d), .flash_dq_oe_n_out(h_oe_n),
        .ready_busy_in(rb));
    pfb_flash_model #(.MAKER_CODE(MAKER), .CONT_CODE(CONT)) flash (.ce_n_in(ce_n), .oe_n_in(oe_n),
        .we_n_in(we_n), .clear_n_in(clr_n), .word_in(word), .clear_hv_in(clr_hv), .hv_in(hv),
        .addr_in(fa), .dq_in(dq), .dq_out(f_d), .dq_oe_n_out(f_oe_n), .ready_busy_out(rb));
    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in   <= 1'b0;
        #1 rd_v = reg_rdata_out;
    endtask : rd
    task automatic go(input logic [5:0] c);
        wr(4'h0, {26'h0, c});
        for (int k = 0; k < 30; k++) begin
            rd(4'h4);
            if (rd_v[0] === 1'b0) break;
        end
    endtask : go
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    // A write strobe without select, or beside output drive, is a bus fault
    always @(posedge sys_clk_in) begin
        cyc++;
        if (!rst_in && !we_n && (ce_n || !oe_n)) chk("write_pins", 32'h0, 32'h1);
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
        rst_in = 1'b1;
        repeat (8) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        chk("idle_ce", 32'h1, {31'h0, ce_n});
        rd(4'h5);
        chk("id_reset", 32'h00a5, rd_v);
        rd(4'h7);
        chk("unmapped", 32'h0, rd_v);
        foreach (rows[i]) begin
            wr(4'h1, {12'h0, rows[i].addr});
            if (rows[i].wd != 16'h0) begin
                wr(4'h2, {16'h0, rows[i].wd});
                go((rows[i].ctl & 6'h08) | 6'h01);
            end
            go(rows[i].ctl | 6'h02);
            rd(4'h3);
            chk("row_rdata", {16'h0, rows[i].ex}, rd_v);
        end
        // Elevated clear lets a protected word change, and removing it locks the word again
        wr(4'h1, 32'h40003);
        wr(4'h2, 32'h2468);
        go(6'h29);
        chk("clear_hv_pin", 32'h1, {31'h0, clr_hv});
        go(6'h0a);
        rd(4'h3);
        chk("unprot_write", 32'h2468, rd_v);
        wr(4'h2, 32'h1111);
        go(6'h09);
        go(6'h0a);
        rd(4'h3);
        chk("reprotect", 32'h2468, rd_v);
        wr(4'h0, 32'h18);
        @(posedge sys_clk_in);
        chk("clear_pin", 32'h0, {31'h0, clr_n});
        wr(4'h5, 32'h5a5a);
        rd(4'h5);
        chk("id_write", 32'h5a5a, rd_v);
        // Reset in the middle of a cycle must drop select and restore the registers
        wr(4'h0, 32'h0a);
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        chk("rst_ce", 32'h1, {31'h0, ce_n});
        rd(4'h5);
        chk("rst_id", 32'h00a5, rd_v);
        rd(4'h4);
        chk("rst_status", 32'h2, rd_v);
        // Address and control writes during a busy cycle must be refused
        wr(4'h1, 32'h4);
        wr(4'h2, 32'h7777);
        wr(4'h0, 32'h9);
        wr(4'h1, 32'h9);
        go(6'h00);
        rd(4'h0);
        chk("ctrl_refuse", 32'h9, rd_v);
        go(6'h0a);
        rd(4'h3);
        chk("busy_refuse", 32'h7777, rd_v);
        rd(4'h4);
        chk("ready_seen", 32'h2, rd_v & 32'h3);
        conclude();
    end
endmodule : pfb_host_tb
`default_nettype wire
